/* File: core/rap_pkg.sv */
// Purpose: Shared constants for the region access protection unit
// Assumes: 32-bit addresses, power-of-two region sizes
// Notes: Permission encodings are plain two-bit codes
package rap_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int RAP_REGIONS = 8;
  localparam int RAP_SUBREGIONS = 8;
  localparam int RAP_IDX_W = 3;
  localparam int RAP_ADDR_W = 32;
  localparam int RAP_SIZE_W = 5;
  // Smallest size code that allows subregions (256 bytes)
  localparam logic [4:0] RAP_SUB_MIN_SIZE = 5'h07;

  // ----------------------------------------
  // Permission codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    RAP_PERM_NONE = 2'b00,
    RAP_PERM_RO = 2'b01,
    RAP_PERM_RW = 2'b10,
    RAP_PERM_RSV = 2'b11
  } rap_perm_e;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RAP_RST_ENABLE = 1'b0;
  localparam logic [31:0] RAP_RST_BASE = 32'h0000_0000;
  localparam logic [4:0] RAP_RST_SIZE = 5'h00;
  localparam logic [7:0] RAP_RST_SUBDIS = 8'h00;
  localparam logic [1:0] RAP_RST_PERM = 2'b00;
  localparam logic RAP_RST_VALID = 1'b0;

  // Checker states
  typedef enum logic [1:0] {
    RAP_ST_IDLE = 2'b00,
    RAP_ST_PASS = 2'b01,
    RAP_ST_FAULT = 2'b10
  } rap_state_e;

endpackage

/* File: core/rap_unit.sv */
// Purpose: Checks each core access against eight protection regions
// Assumes: Inputs synchronous to clk_sys; core holds request until done
// Notes: One cycle check latency; result registered
//
// Contract
// - Up to eight configurable regions compare every checked access.
// - Each region of 256 bytes or more splits into eight equal subregions, each individually disableable.
// - Access hitting no enabled region raises the memory-management fault.
// - Access hitting a region that forbids its kind raises the fault.
// - Read-only region allows reads, rejects writes.
// - Access-disabled region rejects every access.
// - Rejected access never reaches memory; only the fault is signalled.
`timescale 1ns/1ns
`default_nettype none
module rap_unit (
  input wire logic clk_sys,
  input wire logic srst,
  // Configuration write port
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_idx,
  input wire logic cfg_valid,
  input wire logic [31:0] cfg_base,
  input wire logic [4:0] cfg_size,
  input wire logic [7:0] cfg_subdis,
  input wire logic [1:0] cfg_perm,
  input wire logic cfg_enable_wr,
  input wire logic cfg_enable,
  output logic enable,
  // Core side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  output logic req_done,
  output logic fault,
  output logic [31:0] fault_addr,
  // Bus matrix side
  output logic mem_valid,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ready
);

  // ----------------------------------------
  // Region lookup
  // ----------------------------------------
  // Size code n (0 to 30) covers 2^(n+1) bytes; code 31 wraps the 5-bit shift to 0 and matches one address; aligned base assumed by software
  function automatic logic rap_hit(input logic [31:0] base, input logic [4:0] size,
                                   input logic [7:0] subdis, input logic [31:0] addr);
    logic [31:0] mask;
    logic [2:0] sub;
    logic [5:0] sh;
    mask = 32'hFFFF_FFFF << (size + 5'h01);
    sh = {1'b0, size} - 6'h02;
    sub = 3'(addr >> sh);
    rap_hit = ((addr & mask) == (base & mask))
              && !(size >= rap_pkg::RAP_SUB_MIN_SIZE && subdis[sub]);
  endfunction

  logic [7:0] reg_valid;
  logic [31:0] reg_base [8];
  logic [4:0] reg_size [8];
  logic [7:0] reg_subdis [8];
  logic [1:0] reg_perm [8];
  logic [7:0] next_valid;
  logic [31:0] next_base [8];
  logic [4:0] next_size [8];
  logic [7:0] next_subdis [8];
  logic [1:0] next_perm [8];
  logic next_enable;

  // Config storage update
  always_comb
  begin
    next_valid = reg_valid;
    next_base = reg_base;
    next_size = reg_size;
    next_subdis = reg_subdis;
    next_perm = reg_perm;
    next_enable = enable;
    if (cfg_wr)
    begin
      next_valid[cfg_idx] = cfg_valid;
      next_base[cfg_idx] = cfg_base;
      next_size[cfg_idx] = cfg_size;
      next_subdis[cfg_idx] = cfg_subdis;
      next_perm[cfg_idx] = cfg_perm;
    end
    if (cfg_enable_wr)
      next_enable = cfg_enable;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      reg_valid <= {8{rap_pkg::RAP_RST_VALID}};
      enable <= rap_pkg::RAP_RST_ENABLE;
      for (int i = 0; i < rap_pkg::RAP_REGIONS; i++)
      begin
        reg_base[i] <= rap_pkg::RAP_RST_BASE;
        reg_size[i] <= rap_pkg::RAP_RST_SIZE;
        reg_subdis[i] <= rap_pkg::RAP_RST_SUBDIS;
        reg_perm[i] <= rap_pkg::RAP_RST_PERM;
      end
    end
    else
    begin
      reg_valid <= next_valid;
      enable <= next_enable;
      reg_base <= next_base;
      reg_size <= next_size;
      reg_subdis <= next_subdis;
      reg_perm <= next_perm;
    end
  end

  // Highest-numbered hit wins, so later regions can carve exceptions
  logic any_hit;
  logic [1:0] hit_perm;
  logic allowed;
  always_comb
  begin
    any_hit = 1'b0;
    hit_perm = rap_pkg::RAP_PERM_NONE;
    for (int i = 0; i < rap_pkg::RAP_REGIONS; i++)
    begin
      if (reg_valid[i] && rap_hit(reg_base[i], reg_size[i], reg_subdis[i], req_addr))
      begin
        any_hit = 1'b1;
        hit_perm = reg_perm[i];
      end
    end
    case (hit_perm)
      rap_pkg::RAP_PERM_RW: allowed = any_hit;
      rap_pkg::RAP_PERM_RO: allowed = any_hit && !req_write;
      default: allowed = 1'b0;
    endcase
    if (!enable)
      allowed = 1'b1;
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  rap_pkg::rap_state_e state, next_state;
  logic [31:0] next_addr, next_wdata, next_fault_addr;
  logic next_write, next_done, next_fault;

  // Decision is taken once per request and held while memory is busy
  always_comb
  begin
    next_state = state;
    next_addr = mem_addr;
    next_wdata = mem_wdata;
    next_write = mem_write;
    next_fault_addr = fault_addr;
    next_done = 1'b0;
    next_fault = 1'b0;
    case (state)
      rap_pkg::RAP_ST_IDLE:
      begin
        if (req_valid)
        begin
          if (allowed)
          begin
            next_state = rap_pkg::RAP_ST_PASS;
            next_addr = req_addr;
            next_wdata = req_wdata;
            next_write = req_write;
          end
          else
          begin
            next_state = rap_pkg::RAP_ST_FAULT;
            next_fault = 1'b1;
            next_done = 1'b1;
            next_fault_addr = req_addr;
          end
        end
      end
      rap_pkg::RAP_ST_PASS:
      begin
        if (mem_ready)
        begin
          next_state = rap_pkg::RAP_ST_IDLE;
          next_done = 1'b1;
        end
      end
      rap_pkg::RAP_ST_FAULT:
        next_state = rap_pkg::RAP_ST_IDLE;
      default:
        next_state = rap_pkg::RAP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state <= rap_pkg::RAP_ST_IDLE;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      mem_write <= 1'b0;
      fault_addr <= 32'h0000_0000;
      req_done <= 1'b0;
      fault <= 1'b0;
    end
    else
    begin
      state <= next_state;
      mem_addr <= next_addr;
      mem_wdata <= next_wdata;
      mem_write <= next_write;
      fault_addr <= next_fault_addr;
      req_done <= next_done;
      fault <= next_fault;
    end
  end

  // Only the pass state ever presents a request to memory
  assign mem_valid = (state == rap_pkg::RAP_ST_PASS);
  assign req_ready = (state == rap_pkg::RAP_ST_IDLE);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_no_leak;
    @(posedge clk_sys) disable iff (srst)
    (state == rap_pkg::RAP_ST_IDLE && req_valid && !allowed) |=> !mem_valid && fault;
  endproperty
  a_no_leak: assert property (p_no_leak) else $error("blocked access reached memory");

  property p_disabled_passes;
    @(posedge clk_sys) disable iff (srst)
    (state == rap_pkg::RAP_ST_IDLE && req_valid && !enable) |=> mem_valid && !fault;
  endproperty
  a_disabled_passes: assert property (p_disabled_passes) else $error("unchecked access not passed");

  property p_miss_faults;
    @(posedge clk_sys) disable iff (srst)
    (state == rap_pkg::RAP_ST_IDLE && req_valid && enable && !any_hit) |=> fault;
  endproperty
  a_miss_faults: assert property (p_miss_faults) else $error("miss did not fault");

  property p_ro_write;
    @(posedge clk_sys) disable iff (srst)
    (state == rap_pkg::RAP_ST_IDLE && req_valid && enable && any_hit
     && hit_perm == rap_pkg::RAP_PERM_RO) |=> (fault == $past(req_write));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only check wrong");

  property p_none_faults;
    @(posedge clk_sys) disable iff (srst)
    (state == rap_pkg::RAP_ST_IDLE && req_valid && enable && hit_perm == rap_pkg::RAP_PERM_NONE)
    |=> fault ##1 req_ready;
  endproperty
  a_none_faults: assert property (p_none_faults) else $error("disabled region passed");

  property p_rw_passes;
    @(posedge clk_sys) disable iff (srst)
    (state == rap_pkg::RAP_ST_IDLE && req_valid && enable && any_hit
     && hit_perm == rap_pkg::RAP_PERM_RW) |=> mem_valid && mem_addr == $past(req_addr);
  endproperty
  a_rw_passes: assert property (p_rw_passes) else $error("permitted access blocked");

  property p_fault_addr;
    @(posedge clk_sys) disable iff (srst)
    fault |-> req_done && fault_addr == $past(req_addr);
  endproperty
  a_fault_addr: assert property (p_fault_addr) else $error("fault address wrong");

  property p_cfg_store;
    @(posedge clk_sys) disable iff (srst)
    cfg_wr |=> reg_valid[$past(cfg_idx)] == $past(cfg_valid) && reg_perm[$past(cfg_idx)] == $past(cfg_perm);
  endproperty
  a_cfg_store: assert property (p_cfg_store) else $error("config not stored");

  property p_sub_block;
    @(posedge clk_sys) disable iff (srst)
    (reg_valid[0] && reg_size[0] >= rap_pkg::RAP_SUB_MIN_SIZE && reg_subdis[0] == 8'hFF)
    |-> !rap_hit(reg_base[0], reg_size[0], reg_subdis[0], req_addr);
  endproperty
  a_sub_block: assert property (p_sub_block) else $error("disabled subregion hit");

endmodule
`default_nettype wire

/* File: tb/rap_mem_model.sv */
// Purpose: Memory responder on the bus matrix side of the protection unit
// Assumes: mem_* held stable until the mem_ready edge
// Notes: Wait states set by mem_delay; ready only while a request stands
`timescale 1ns/1ns
`default_nettype none
module rap_mem_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_delay,
  output logic mem_ready,
  output logic [31:0] n_acc,
  output logic [31:0] last_addr,
  output logic [31:0] last_wdata,
  output logic last_write
);
  logic [3:0] wait_cnt;
  // Ready after mem_delay+1 wait states; counts every completed access
  always_ff @(posedge clk_sys)
  begin
    if (srst || !mem_valid || mem_ready)
    begin
      wait_cnt <= 4'h0;
      mem_ready <= 1'b0;
    end
    else if (wait_cnt == mem_delay)
      mem_ready <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
    if (srst)
      n_acc <= 32'h0;
    else if (mem_valid && mem_ready)
    begin
      n_acc <= n_acc + 32'h1;
      last_addr <= mem_addr;
      last_wdata <= mem_wdata;
      last_write <= mem_write;
    end
  end
endmodule
`default_nettype wire

/* File: tb/region_access_protection_tb.sv */
// Purpose: Self-checking bench for the region access protection unit
// Assumes: One outstanding core request; memory answers via rap_mem_model
// Notes: Requests dropped at the edge that ends them, so no stray retry
`timescale 1ns/1ns
`default_nettype none
module region_access_protection_tb;
  logic clk_sys = 0, srst = 1, cfg_wr = 0, cfg_valid = 0, cfg_enable_wr = 0, cfg_enable = 0;
  logic req_valid = 0, req_write = 0, enable, req_ready, req_done, fault, mem_valid, mem_write, mem_ready;
  logic last_write;
  logic [2:0] cfg_idx = 0;
  logic [4:0] cfg_size = 0;
  logic [7:0] cfg_subdis = 0;
  logic [1:0] cfg_perm = 0;
  logic [3:0] mem_delay = 0;
  logic [31:0] cfg_base = 0, req_addr = 0, req_wdata = 0;
  logic [31:0] fault_addr, mem_addr, mem_wdata, n_acc, last_addr, last_wdata;
  int n_errors = 0, checked = 0;
  // Clock, 20 ns period
  always #10 clk_sys = ~clk_sys;
  rap_unit i_dut (.clk_sys(clk_sys), .srst(srst), .cfg_wr(cfg_wr), .cfg_idx(cfg_idx), .cfg_valid(cfg_valid),
    .cfg_base(cfg_base), .cfg_size(cfg_size), .cfg_subdis(cfg_subdis), .cfg_perm(cfg_perm),
    .cfg_enable_wr(cfg_enable_wr), .cfg_enable(cfg_enable), .enable(enable), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .req_done(req_done), .fault(fault), .fault_addr(fault_addr), .mem_valid(mem_valid),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready));
  rap_mem_model i_mem (.clk_sys(clk_sys), .srst(srst), .mem_valid(mem_valid), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_delay(mem_delay), .mem_ready(mem_ready),
    .n_acc(n_acc), .last_addr(last_addr), .last_wdata(last_wdata), .last_write(last_write));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Write one region slot; active from the next edge
  task automatic region(input logic [2:0] idx, input logic v, input logic [31:0] base, input logic [4:0] sz,
    input logic [7:0] sd, input logic [1:0] perm);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    {cfg_idx, cfg_valid, cfg_base, cfg_size, cfg_subdis, cfg_perm} <= {idx, v, base, sz, sd, perm};
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  task automatic glob(input logic en);
    @(posedge clk_sys);
    cfg_enable_wr <= 1'b1;
    cfg_enable <= en;
    @(posedge clk_sys);
    cfg_enable_wr <= 1'b0;
    @(negedge clk_sys);
    chk("enable", enable, en);
  endtask
  // One core access; expects either a block or a pass to memory
  task automatic acc(input logic wr, input logic [31:0] addr, input logic exp_f);
    logic [31:0] n0;
    int i;
    n0 = n_acc;
    @(posedge clk_sys);
    {req_valid, req_write, req_addr, req_wdata} <= {1'b1, wr, addr, ~addr};
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk_sys);
      if ((exp_f && req_ready) || (mem_valid && mem_ready))
        break;
    end
    req_valid <= 1'b0;
    @(negedge clk_sys);
    chk("req_done", req_done, 1'b1);
    chk("fault", fault, exp_f);
    if (exp_f)
      chk("fault_addr", fault_addr, addr);
    repeat (2) @(posedge clk_sys);
    chk("mem accesses", n_acc, n0 + {31'h0, !exp_f});
    if (!exp_f)
    begin
      chk("mem addr", last_addr, addr);
      chk("mem data", last_wdata, ~addr);
      chk("mem dir", {31'h0, last_write}, {31'h0, wr});
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("idle", {enable, req_ready, fault, mem_valid}, 4'h4);
    acc(1'b1, 32'h1000_0000, 1'b0);
    acc(1'b0, 32'hFFFF_FFFC, 1'b0);
    $display("test reset/unchecked done");
  endtask
  task automatic t_overlap();
    mem_delay <= 4'h3;
    region(3'h0, 1'b1, 32'h2000_0000, 5'h0F, 8'h00, rap_pkg::RAP_PERM_RW);
    region(3'h7, 1'b1, 32'h2000_0000, 5'h07, 8'h00, rap_pkg::RAP_PERM_RO);
    glob(1'b1);
    acc(1'b1, 32'h1000_0000, 1'b1);
    acc(1'b1, 32'h2000_1000, 1'b0);
    acc(1'b1, 32'h2000_0010, 1'b1);
    acc(1'b0, 32'h2000_0010, 1'b0);
    acc(1'b1, 32'h2000_0100, 1'b0);
    $display("test overlap/read-only done");
  endtask
  task automatic t_perm();
    mem_delay <= 4'h0;
    region(3'h3, 1'b1, 32'h3000_0000, 5'h0B, 8'h00, rap_pkg::RAP_PERM_NONE);
    acc(1'b0, 32'h3000_0FFC, 1'b1);
    region(3'h3, 1'b1, 32'h3000_0000, 5'h0B, 8'h00, rap_pkg::RAP_PERM_RSV);
    acc(1'b0, 32'h3000_0000, 1'b1);
    region(3'h3, 1'b1, 32'h3000_0000, 5'h0B, 8'h00, rap_pkg::RAP_PERM_RW);
    acc(1'b1, 32'h3000_0800, 1'b0);
    region(3'h3, 1'b0, 32'h3000_0000, 5'h0B, 8'h00, rap_pkg::RAP_PERM_RW);
    acc(1'b1, 32'h3000_0800, 1'b1);
    $display("test permissions done");
  endtask
  task automatic t_sub();
    region(3'h4, 1'b1, 32'h4000_0000, 5'h07, 8'h84, rap_pkg::RAP_PERM_RW);
    acc(1'b0, 32'h4000_0040, 1'b1);
    acc(1'b1, 32'h4000_005C, 1'b1);
    acc(1'b1, 32'h4000_0060, 1'b0);
    acc(1'b0, 32'h4000_003C, 1'b0);
    acc(1'b0, 32'h4000_00E0, 1'b1);
    // Below 256 bytes the subregion mask is ignored
    region(3'h5, 1'b1, 32'h5000_0000, 5'h06, 8'hFF, rap_pkg::RAP_PERM_RW);
    acc(1'b0, 32'h5000_0010, 1'b0);
    // Every subregion of the large region switched off
    region(3'h0, 1'b1, 32'h2000_0000, 5'h0F, 8'hFF, rap_pkg::RAP_PERM_RW);
    acc(1'b1, 32'h2000_1000, 1'b1);
    glob(1'b0);
    acc(1'b1, 32'h4000_0040, 1'b0);
    $display("test subregions/disable done");
  endtask
  // Watchdog: whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    t_reset();
    t_overlap();
    t_perm();
    t_sub();
    close_out();
  end
endmodule
`default_nettype wire
